// ==== rtl/port_compare_pkg.sv ====
package port_compare_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int WORD_BITS = 10;
	localparam int NIBBLE_BITS = 4;
	localparam int PORT_D_BITS = 6;

	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	localparam logic [9:0] SET_SINGLE_PORT_CODE = 10'h28D;
	localparam logic [9:0] INDEXED_PORT_SET_CODE = 10'h015;
	localparam logic [9:0] MEMORY_COMPARE_CODE = 10'h026;
	localparam logic [5:0] IMMEDIATE_COMPARE_UPPER = 6'h07;

	// ----------------------------------------
	// Reset values and limits
	// ----------------------------------------
	localparam logic PORT_C_RESET = 1'b0;
	localparam logic [5:0] PORT_D_RESET = 6'h00;
	localparam logic [3:0] INDEX_LAST = 4'h5;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [5:0] upper;
		logic [3:0] imm;
	} instr_type;

	typedef struct packed {
		logic [3:0] accumulator;
		logic [3:0] index_reg;
		logic [3:0] mem_nibble;
	} core_regs_type;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_SET_SINGLE,
		OP_INDEXED_SET,
		OP_IMM_COMPARE,
		OP_MEM_COMPARE
	} op_type;

endpackage : port_compare_pkg

// ==== rtl/port_set_and_compare_skip_ops.sv ====
// Functional notes
// - Indexed set raises port bit at index
// - Index addresses only bits zero to five
// - Index above five makes it a no-op
// - Immediate compare: upper bits 000111, nibble low
// - Immediate equal skips next, no state change
// - Immediate unequal executes next normally
// - Memory compare skips on equality only
module port_set_and_compare_skip_ops
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Instruction issue
	input wire logic issue_valid,
	input wire port_compare_pkg::instr_type instr_word,
	output logic issue_ready,
	// Core state, memory nibble is M at the data pointer
	input wire port_compare_pkg::core_regs_type core_regs,
	// Port latches
	output logic port_c,
	output logic [port_compare_pkg::PORT_D_BITS-1:0] port_d,
	// Sequencer answer
	output logic op_done,
	output logic skip_next
);
	import port_compare_pkg::*;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	typedef enum logic {
		ST_IDLE,
		ST_IMM_SECOND
	} state_type;

	function automatic op_type decode_op(input instr_type w);
		op_type r;
		r = OP_NONE;
		if (w == SET_SINGLE_PORT_CODE)
			r = OP_SET_SINGLE;
		else if (w == INDEXED_PORT_SET_CODE)
			r = OP_INDEXED_SET;
		else if (w == MEMORY_COMPARE_CODE)
			r = OP_MEM_COMPARE;
		else if (w.upper == IMMEDIATE_COMPARE_UPPER)
			r = OP_IMM_COMPARE;
		return r;
	endfunction : decode_op

	state_type state_reg;
	op_type op_now;
	logic accept;
	logic index_ok;
	logic [3:0] imm_reg;
	logic [3:0] acc_reg;
	logic port_c_reg;
	logic [PORT_D_BITS-1:0] port_d_reg;
	logic done_reg;
	logic skip_reg;

	assign op_now = decode_op(instr_word);
	// Second cycle of the immediate compare holds off the next issue
	assign issue_ready = (state_reg == ST_IDLE);
	assign accept = issue_valid && issue_ready;
	assign index_ok = (core_regs.index_reg <= INDEX_LAST);

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (reset)
			state_reg <= ST_IDLE;
		else
		begin
			case (state_reg)
				ST_IDLE:
					if (accept && op_now == OP_IMM_COMPARE)
						state_reg <= ST_IMM_SECOND;
				ST_IMM_SECOND:
					state_reg <= ST_IDLE;
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// Operands held so a late accumulator change cannot alter the result
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			imm_reg <= 4'h0;
			acc_reg <= 4'h0;
		end
		else if (accept && op_now == OP_IMM_COMPARE)
		begin
			imm_reg <= instr_word.imm;
			acc_reg <= core_regs.accumulator;
		end
	end

	// ----------------------------------------
	// Port latches
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (reset)
			port_c_reg <= PORT_C_RESET;
		else if (accept && op_now == OP_SET_SINGLE)
			port_c_reg <= 1'b1;
	end

	generate
		for (genvar i = 0; i < PORT_D_BITS; i++)
		begin : g_port_d
			always_ff @(posedge mclk)
			begin
				if (reset)
					port_d_reg[i] <= PORT_D_RESET[i];
				else if (accept && op_now == OP_INDEXED_SET && index_ok
					&& core_regs.index_reg == 4'(i))
					port_d_reg[i] <= 1'b1;
			end
		end
	endgenerate

	// ----------------------------------------
	// Completion and skip
	// ----------------------------------------
	// Accumulator and carry are never written here; only skip is reported
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			done_reg <= 1'b0;
			skip_reg <= 1'b0;
		end
		else if (state_reg == ST_IMM_SECOND)
		begin
			done_reg <= 1'b1;
			skip_reg <= (acc_reg == imm_reg);
		end
		else if (accept && op_now != OP_IMM_COMPARE)
		begin
			done_reg <= 1'b1;
			skip_reg <= (op_now == OP_MEM_COMPARE)
				&& (core_regs.accumulator == core_regs.mem_nibble);
		end
		else
		begin
			done_reg <= 1'b0;
			skip_reg <= 1'b0;
		end
	end

	assign port_c = port_c_reg;
	assign port_d = port_d_reg;
	assign op_done = done_reg;
	assign skip_next = skip_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_port_c_set: assert property (@(posedge mclk) disable iff (reset)
		accept && op_now == OP_SET_SINGLE |=> port_c && op_done && !skip_next)
		else $error("port c not set after single port op");

	a_port_d_bit: assert property (@(posedge mclk) disable iff (reset)
		accept && op_now == OP_INDEXED_SET && core_regs.index_reg <= 4'h5
		|=> port_d == ($past(port_d) | (6'h01 << $past(core_regs.index_reg))))
		else $error("indexed port bit not set");

	a_port_d_cause: assert property (@(posedge mclk) disable iff (reset)
		(port_d != $past(port_d)) |-> $past(accept) && $past(op_now) == OP_INDEXED_SET
		&& $past(core_regs.index_reg) <= 4'h5)
		else $error("port d changed without valid indexed set");

	a_port_d_nop: assert property (@(posedge mclk) disable iff (reset)
		accept && op_now == OP_INDEXED_SET && core_regs.index_reg > 4'h5
		|=> $stable(port_d) && op_done && !skip_next)
		else $error("out of range index changed port d");

	a_imm_two_cycle: assert property (@(posedge mclk) disable iff (reset)
		accept && instr_word.upper == 6'h07 && instr_word != 10'h015
		|=> !issue_ready && !op_done ##1 op_done && issue_ready)
		else $error("immediate compare timing wrong");

	a_imm_equal: assert property (@(posedge mclk) disable iff (reset)
		accept && op_now == OP_IMM_COMPARE && core_regs.accumulator == instr_word.imm
		|-> ##2 skip_next && op_done)
		else $error("equal immediate did not skip");

	a_imm_unequal: assert property (@(posedge mclk) disable iff (reset)
		accept && op_now == OP_IMM_COMPARE && core_regs.accumulator != instr_word.imm
		|-> ##2 !skip_next && op_done)
		else $error("unequal immediate skipped");

	a_mem_compare: assert property (@(posedge mclk) disable iff (reset)
		accept && op_now == OP_MEM_COMPARE
		|=> op_done && (skip_next == $past(core_regs.accumulator == core_regs.mem_nibble)))
		else $error("memory compare skip wrong");

	a_port_c_cause: assert property (@(posedge mclk) disable iff (reset)
		$rose(port_c) |-> $past(accept) && $past(op_now) == OP_SET_SINGLE)
		else $error("port c rose without single port op");

	// Words offered in the stall cycle must leave the ports alone
	a_stall_refuse: assert property (@(posedge mclk) disable iff (reset)
		!issue_ready |=> $stable(port_c) && $stable(port_d))
		else $error("port changed while issue stalled");

	a_mem_ports: assert property (@(posedge mclk) disable iff (reset)
		accept && op_now == OP_MEM_COMPARE |=> $stable(port_c) && $stable(port_d))
		else $error("memory compare changed a port");

	// Skip only ever comes from the two compares
	a_skip_source: assert property (@(posedge mclk) disable iff (reset)
		skip_next |-> $past(state_reg) == ST_IMM_SECOND
		|| ($past(accept) && $past(op_now) == OP_MEM_COMPARE))
		else $error("skip without a compare");

endmodule : port_set_and_compare_skip_ops

// ==== testbench/tb_top.sv ====
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import port_compare_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic issue_valid = 1'b0;
	instr_type instr_word = '0;
	core_regs_type core_regs = '0;
	logic issue_ready;
	logic port_c;
	logic [PORT_D_BITS-1:0] port_d;
	logic op_done;
	logic skip_next;
	int num_errors = 0;
	int checks = 0;

	always #4 mclk = ~mclk;

	port_set_and_compare_skip_ops DUT (
		.mclk(mclk),
		.reset(reset),
		.issue_valid(issue_valid),
		.instr_word(instr_word),
		.issue_ready(issue_ready),
		.core_regs(core_regs),
		.port_c(port_c),
		.port_d(port_d),
		.op_done(op_done),
		.skip_next(skip_next)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Outputs looked at mid-cycle, after the edge's updates land
	task outs(input logic rdy, input logic done, input logic skip);
		chk({5'h0, issue_ready, op_done, skip_next}, {5'h0, rdy, done, skip});
	endtask : outs

	// Valid stays up so calls can run back to back
	task issue(input logic [9:0] word, input logic [3:0] acc, idx, mem);
		issue_valid = 1'b1;
		instr_word = word;
		core_regs = {acc, idx, mem};
		@(posedge mclk);
		@(negedge mclk);
	endtask : issue

	task idle();
		issue_valid = 1'b0;
		@(negedge mclk);
	endtask : idle

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task test_single();
		outs(1'b1, 1'b0, 1'b0);
		chk({1'b0, port_c, port_d}, 8'h00);
		issue(SET_SINGLE_PORT_CODE, 4'h3, 4'h2, 4'h3);
		outs(1'b1, 1'b1, 1'b0);
		chk({7'h0, port_c}, 8'h01);
		idle();
		outs(1'b1, 1'b0, 1'b0);
	endtask : test_single

	// Out-of-range indices first, so a stray write shows on a clean port
	task test_indexed();
		logic [5:0] exp;
		exp = 6'h00;
		for (int k = 15; k >= 0; k--)
		begin
			issue(INDEXED_PORT_SET_CODE, 4'h0, 4'(k), 4'h0);
			if (k <= 5)
				exp[k] = 1'b1;
			outs(1'b1, 1'b1, 1'b0);
			chk({2'b00, port_d}, {2'b00, exp});
		end
		idle();
	endtask : test_indexed

	// Accumulator flipped after accept: the decision must use the sampled value
	task test_immediate();
		for (int n = 0; n < 16; n++)
		begin
			issue({IMMEDIATE_COMPARE_UPPER, 4'(n)}, 4'h9, 4'h0, 4'h6);
			issue_valid = 1'b0;
			core_regs.accumulator = 4'h6;
			outs(1'b0, 1'b0, 1'b0);
			@(negedge mclk);
			outs(1'b1, 1'b1, n == 9);
		end
		@(negedge mclk);
	endtask : test_immediate

	task test_memory();
		for (int a = 0; a < 16; a++)
		begin
			issue(MEMORY_COMPARE_CODE, 4'(a), 4'h0, 4'h6);
			outs(1'b1, 1'b1, a == 6);
		end
		idle();
		chk({1'b0, port_c, port_d}, 8'h7F);
	endtask : test_memory

	// Reset in mid-run clears both latches; first issue right at release
	task test_reset();
		issue_valid = 1'b0;
		reset = 1'b1;
		repeat (2) @(negedge mclk);
		outs(1'b1, 1'b0, 1'b0);
		chk({1'b0, port_c, port_d}, 8'h00);
		reset = 1'b0;
		issue(SET_SINGLE_PORT_CODE, 4'h0, 4'h0, 4'h0);
		outs(1'b1, 1'b1, 1'b0);
		chk({1'b0, port_c, port_d}, 8'h40);
		idle();
	endtask : test_reset

	// A word offered during the stall is refused; unknown words only complete
	task test_refused();
		issue({IMMEDIATE_COMPARE_UPPER, 4'h3}, 4'h3, 4'h0, 4'h0);
		outs(1'b0, 1'b0, 1'b0);
		issue(INDEXED_PORT_SET_CODE, 4'h3, 4'h0, 4'h0);
		outs(1'b1, 1'b1, 1'b1);
		chk({1'b0, port_c, port_d}, 8'h40);
		issue(10'h000, 4'h0, 4'h0, 4'h0);
		outs(1'b1, 1'b1, 1'b0);
		chk({1'b0, port_c, port_d}, 8'h40);
		idle();
	endtask : test_refused

	// ----------------------------------------
	// Verdict and sequence
	// ----------------------------------------
	task give_verdict();
		if (num_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict

	initial
	begin
		#20000;
		num_errors++;
		give_verdict();
	end

	initial
	begin
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		reset = 1'b0;
		test_single();
		test_indexed();
		test_immediate();
		test_memory();
		test_reset();
		test_refused();
		give_verdict();
	end
endmodule : tb_top
